// [design/rss_defines.vh]
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH

// Power-up delay, nominal, in ms
`define RSS_PWRUP_DELAY_MS 72
// Internal RC clock for the delay timer, in Hz
`define RSS_RC_CLK_HZ 40000
// Delay in RC cycles: ms * Hz / 1000
`define RSS_PWRUP_RC_CYCLES (`RSS_PWRUP_DELAY_MS * `RSS_RC_CLK_HZ / 1000)
// Brown-out minimum duration, in RC cycles
`define RSS_BROWNOUT_MIN_RC_CYCLES 4
// Oscillator start-up count, in oscillator input cycles
`define RSS_OSC_STARTUP_CYCLES 1024
// Oscillator mode codes
`define RSS_MODE_LP 2'h0
`define RSS_MODE_XT 2'h1
`define RSS_MODE_HS 2'h2
`define RSS_MODE_RC 2'h3

`endif

// [design/rss_edge_counter.v]
`timescale 1ns/100ps
module rss_edge_counter #(
    parameter WIDTH = 12
) (
    input wire clk,
    input wire rst_n,
    input wire clear,
    input wire tick,
    input wire [WIDTH-1:0] limit,
    output reg done
);
    reg [WIDTH-1:0] count;

    // Counts clock cycles with tick high while not cleared; done holds once limit reached
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= {WIDTH{1'b0}};
            done <= 1'b0;
        end
        else if (clear)
        begin
            count <= {WIDTH{1'b0}};
            done <= 1'b0;
        end
        else if (!done && tick)
        begin
            if (count == limit - {{(WIDTH-1){1'b0}}, 1'b1})
                done <= 1'b1;
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule

// [design/rss_reset_startup_sequencer.v]
// Contract
// R01: Core stays in reset while power-on detect reports supply too low; code does so only until the detect's first rise after rst_n.
// R02: Power-on path resets only on supply rise, never on supply fall.
// R03: System holds device in reset until operating conditions are met.
// R04: Power-up delay runs only after power-on or brown-out; core held. Code also runs it after other_reset.
// R05: Power-up delay counts the internal RC clock, not the oscillator.
// R06: Delay disable bit set skips delay; cleared enables it.
// R07: Configure power-up delay enabled whenever brown-out reset enabled.
// R08: After the delay, count 1024 oscillator input cycles before release.
// R09: Start-up count only in crystal modes, after power-on or wake-up.
// R10: Brown-out enable bit set enables brown-out reset; cleared disables.
// R11: Brown-out resets only when supply low longer than minimum duration; code qualifies at once while the delay runs.
// R12: After any reset, wait for supply above threshold, then run delay.
// R13: Supply dip during delay re-enters brown-out and restarts delay.
// R14: Release only with no source and enabled timers done, in order.
// R15: Delay and brown-out duration are parameters in RC clock cycles.
`timescale 1ns/100ps
`include "rss_defines.vh"
module rss_reset_startup_sequencer #(
    parameter PWRUP_RC_CYCLES = `RSS_PWRUP_RC_CYCLES,
    parameter BROWNOUT_MIN_RC_CYCLES = `RSS_BROWNOUT_MIN_RC_CYCLES,
    parameter OSC_STARTUP_CYCLES = `RSS_OSC_STARTUP_CYCLES
) (
    input wire clk,
    input wire rst_n,
    input wire supply_ok,
    input wire brownout_low,
    input wire other_reset,
    input wire wake_from_sleep,
    input wire rc_clk_in,
    input wire oscillator_input_pin,
    input wire powerup_delay_disable_bit,
    input wire brownout_enable_bit,
    input wire [1:0] osc_mode,
    output reg core_reset,
    output reg brownout_reset_flag,
    output reg [2:0] seq_state
);
    localparam ST_HOLD = 3'h0;
    localparam ST_POWERUP_DELAY_TIMER = 3'h1;
    localparam ST_OST = 3'h2;
    localparam ST_RUN = 3'h3;
    localparam ST_SLEEPWAKE = 3'h4;
    localparam CW = 24;
    localparam OW = 12;
    localparam [CW-1:0] PWRUP_LIM = PWRUP_RC_CYCLES[CW-1:0];
    localparam [CW-1:0] BOR_LIM = BROWNOUT_MIN_RC_CYCLES[CW-1:0];
    localparam [OW-1:0] OST_LIM = OSC_STARTUP_CYCLES[OW-1:0];

    // Two-flop synchronisers for all asynchronous pins
    reg [1:0] s_sup, s_bo, s_oth, s_wake, s_rc, s_osc;
    reg rc_q, osc_q;
    reg [CW-1:0] pwrup_cnt;
    reg [CW-1:0] bor_cnt;
    reg bor_qualified;
    reg sup_prev;
    reg por_armed;
    reg ost_pending;
    reg [2:0] next_state;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_sup <= 2'h0;
            s_bo <= 2'h0;
            s_oth <= 2'h0;
            s_wake <= 2'h0;
            s_rc <= 2'h0;
            s_osc <= 2'h0;
            rc_q <= 1'b0;
            osc_q <= 1'b0;
        end
        else
        begin
            s_sup <= {s_sup[0], supply_ok};
            s_bo <= {s_bo[0], brownout_low};
            s_oth <= {s_oth[0], other_reset};
            s_wake <= {s_wake[0], wake_from_sleep};
            s_rc <= {s_rc[0], rc_clk_in};
            s_osc <= {s_osc[0], oscillator_input_pin};
            rc_q <= s_rc[1];
            osc_q <= s_osc[1];
        end
    end

    wire sup_ok = s_sup[1];
    wire bo_low = s_bo[1] & brownout_enable_bit; // [R10]
    wire rc_tick = s_rc[1] & ~rc_q; // [R05]
    wire osc_tick = s_osc[1] & ~osc_q;
    wire crystal = (osc_mode == `RSS_MODE_LP) | (osc_mode == `RSS_MODE_XT)
        | (osc_mode == `RSS_MODE_HS);
    // Power-on event is a rise of the detect; a fall alone starts nothing
    // Detect only acts until its first rise after rst_n
    wire por_rise = sup_ok & ~sup_prev & por_armed; // [R02]
    wire hold_src = (~sup_ok & por_armed) | bor_qualified | s_oth[1]; // [R01] [R03]
    wire ost_done;

    // Start-up count due only in crystal modes with a pending request
    wire ost_needed = (ost_pending | por_rise) & crystal; // [R09]
    wire ost_clear = (seq_state != ST_OST);

    // Brown-out qualifier: low must persist for the minimum RC cycles, except in the delay state
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bor_cnt <= {CW{1'b0}};
            bor_qualified <= 1'b0;
            sup_prev <= 1'b0;
            por_armed <= 1'b1;
        end
        else
        begin
            sup_prev <= sup_ok;
            if (por_rise)
                por_armed <= 1'b0; // [R02]
            if (!bo_low)
            begin
                bor_cnt <= {CW{1'b0}};
                bor_qualified <= 1'b0; // [R12]
            end
            else if (seq_state == ST_POWERUP_DELAY_TIMER)
                bor_qualified <= 1'b1; // [R13]
            else if (rc_tick && !bor_qualified)
            begin
                if (bor_cnt >= BOR_LIM - 24'h000001)
                    bor_qualified <= 1'b1; // [R11]
                bor_cnt <= bor_cnt + 24'h000001;
            end
        end
    end

    // Skipped timers leave no trace in the state sequence
    always @*
    begin
        next_state = seq_state;
        case (seq_state)
            ST_HOLD:
                if (!hold_src)
                begin
                    if (!powerup_delay_disable_bit)
                        next_state = ST_POWERUP_DELAY_TIMER; // [R06]
                    else if (ost_needed)
                        next_state = ST_OST; // [R06]
                    else
                        next_state = ST_RUN; // [R06]
                end
            ST_POWERUP_DELAY_TIMER:
                if (hold_src)
                    next_state = ST_HOLD; // [R13]
                else if (pwrup_cnt >= PWRUP_LIM)
                begin
                    if (ost_needed)
                        next_state = ST_OST; // [R04] [R14]
                    else
                        next_state = ST_RUN; // [R04] [R14]
                end
            ST_OST:
                if (hold_src)
                    next_state = ST_HOLD;
                else if (!ost_needed || ost_done)
                    next_state = ST_RUN; // [R08] [R09] [R14]
            ST_RUN:
                if (hold_src)
                    next_state = ST_HOLD;
                else if (s_wake[1])
                    next_state = ST_SLEEPWAKE;
            ST_SLEEPWAKE:
                if (hold_src)
                    next_state = ST_HOLD;
                else if (ost_needed)
                    next_state = ST_OST; // [R09]
                else
                    next_state = ST_RUN; // [R09]
            default:
                next_state = ST_HOLD;
        endcase
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seq_state <= ST_HOLD;
            pwrup_cnt <= {CW{1'b0}};
            ost_pending <= 1'b1;
            core_reset <= 1'b1;
            brownout_reset_flag <= 1'b0;
        end
        else
        begin
            seq_state <= next_state;
            // Delay restarts from zero whenever not running
            if (seq_state != ST_POWERUP_DELAY_TIMER || hold_src)
                pwrup_cnt <= {CW{1'b0}}; // [R13]
            else if (rc_tick)
                pwrup_cnt <= pwrup_cnt + 24'h000001; // [R05] [R15]
            // Pending count survives brown-out resets until the core runs
            if (por_rise || next_state == ST_SLEEPWAKE)
                ost_pending <= 1'b1; // [R09]
            else if (seq_state == ST_RUN)
                ost_pending <= 1'b0;
            if (bor_qualified)
                brownout_reset_flag <= 1'b1;
            else if (seq_state == ST_RUN)
                brownout_reset_flag <= 1'b0;
            // Taken from next state so release lines up with run
            core_reset <= (next_state != ST_RUN); // [R14]
        end
    end

    rss_edge_counter #(
        .WIDTH(OW)
    ) u_osc_startup_timer (
        .clk(clk),
        .rst_n(rst_n),
        .clear(ost_clear),
        .tick(osc_tick),
        .limit(OST_LIM),
        .done(ost_done)
    );
endmodule

// [tb/rss_properties.sv]
`timescale 1ns/100ps
module rss_properties (
    input wire clk,
    input wire rst_n,
    input wire supply_ok,
    input wire brownout_low,
    input wire other_reset,
    input wire wake_from_sleep,
    input wire rc_clk_in,
    input wire oscillator_input_pin,
    input wire powerup_delay_disable_bit,
    input wire brownout_enable_bit,
    input wire [1:0] osc_mode,
    input wire core_reset,
    input wire brownout_reset_flag,
    input wire [2:0] seq_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_release_in_run: assert property (!core_reset |-> seq_state == 3'h3)
        else $error("release outside run");
    chk_low_supply_hold: assert property ((seq_state == 3'h0 && !supply_ok)[*3]
        |=> seq_state == 3'h0)
        else $error("left hold on low supply");
    chk_delay_rc_only: assert property ((seq_state == 3'h1 && !rc_clk_in)[*6]
        |=> seq_state <= 3'h1)
        else $error("delay ended without rc edge");
    chk_rc_mode_skip: assert property (osc_mode == 2'h3 |-> seq_state != 3'h2)
        else $error("start-up count in rc mode");
    chk_delay_disabled: assert property (powerup_delay_disable_bit |-> seq_state != 3'h1)
        else $error("delay ran while disabled");
    chk_flag_needs_en: assert property (!brownout_enable_bit |-> !brownout_reset_flag)
        else $error("brown-out flag while disabled");
    chk_dip_in_delay: assert property (seq_state == 3'h1
        && brownout_enable_bit && brownout_low |-> ##[1:4] seq_state == 3'h0)
        else $error("dip in delay not restarted");
    chk_quiet_run_kept: assert property ((seq_state == 3'h3 && !rc_clk_in
        && !wake_from_sleep && !other_reset && supply_ok)[*6] |=> seq_state == 3'h3)
        else $error("run left without cause");
    cov_run: cover property ($rose(seq_state == 3'h3));
    cov_start_count: cover property (seq_state == 3'h1 ##1 seq_state == 3'h2);
    cov_brownout: cover property ($rose(brownout_reset_flag));
endmodule
bind rss_reset_startup_sequencer rss_properties rss_properties_i (.*);

// [tb/rss_reset_startup_sequencer_tb.sv]
`timescale 1ns/100ps
module rss_reset_startup_sequencer_tb;
    localparam PW = 8;
    localparam OS = 8;
    reg clk = 0, rst_n = 0, supply_ok = 0, brownout_low = 0, other_reset = 0;
    reg wake_from_sleep = 0, powerup_delay_disable_bit = 0, brownout_enable_bit = 0;
    reg [1:0] osc_mode = 2'h0;
    reg [7:0] tick = 8'h00;
    wire rc_clk_in = tick[3];
    wire oscillator_input_pin = tick[1];
    wire core_reset, brownout_reset_flag;
    wire [2:0] seq_state;
    integer fails = 0, num_checks = 0, i, pw = 0, os = 0;
    // Disable bit, mode, delay expected, start-up count expected
    localparam [39:0] ROWS = {5'h1c, 5'h19, 5'h15, 5'h11, 5'h0e, 5'h0b, 5'h07, 5'h03};
    reg [4:0] row = 5'h00;
    rss_reset_startup_sequencer #(.PWRUP_RC_CYCLES(PW), .OSC_STARTUP_CYCLES(OS))
        rss_reset_startup_sequencer_i (
        .clk(clk),
        .rst_n(rst_n),
        .supply_ok(supply_ok),
        .brownout_low(brownout_low),
        .other_reset(other_reset),
        .wake_from_sleep(wake_from_sleep),
        .rc_clk_in(rc_clk_in),
        .oscillator_input_pin(oscillator_input_pin),
        .powerup_delay_disable_bit(powerup_delay_disable_bit),
        .brownout_enable_bit(brownout_enable_bit),
        .osc_mode(osc_mode),
        .core_reset(core_reset),
        .brownout_reset_flag(brownout_reset_flag),
        .seq_state(seq_state)
    );
    always #12.5 clk = ~clk;
    always @(negedge clk) tick <= tick + 8'h01;
    always @(posedge clk)
    begin
        pw <= (seq_state === 3'h0 || seq_state === 3'h4) ? 0 : pw + (seq_state === 3'h1);
        os <= (seq_state === 3'h0 || seq_state === 3'h4) ? 0 : os + (seq_state === 3'h2);
    end
    task check(input [31:0] got, input [31:0] lo, input [31:0] hi);
    begin
        num_checks = num_checks + 1;
        if ((^got === 1'bx) || got < lo || got > hi)
        begin
            fails = fails + 1;
            $display("unexpected at %0t: got %h, want %h to %h", $time, got, lo, hi);
        end
    end
    endtask
    task complete_run;
    begin
        if (fails == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task hold(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task restart;
    begin
        rst_n = 0;
        supply_ok = 0;
        hold(10);
        rst_n = 1;
        hold(6);
        check(core_reset, 1, 1);
        supply_ok = 1;
    end
    endtask
    task wait_run;
        integer n;
    begin
        n = 0;
        while (core_reset !== 1'b0 && n < 800)
        begin
            hold(1);
            n = n + 1;
        end
        check(core_reset, 0, 0);
    end
    endtask
    initial
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            row = ROWS[i*5 +: 5];
            {powerup_delay_disable_bit, osc_mode} = row[4:2];
            brownout_enable_bit = i[0] & !row[4];
            restart;
            wait_run;
            check(pw, row[1] * (PW - 1) * 16, row[1] * (PW * 16 + 4));
            check(os, row[0] * (OS - 1) * 4, row[0] * (OS * 4 + 4));
        end
        {powerup_delay_disable_bit, osc_mode, brownout_enable_bit} = 4'h3;
        restart;
        wait_run;
        brownout_low = 1;
        hold(32);
        brownout_low = 0;
        hold(20);
        check(core_reset, 0, 0);
        supply_ok = 0;
        hold(20);
        check(core_reset, 0, 0);
        supply_ok = 1;
        hold(4);
        brownout_low = 1;
        hold(100);
        check(brownout_reset_flag, 1, 1);
        brownout_low = 0;
        hold(40);
        brownout_low = 1;
        hold(8);
        check(core_reset, 1, 1);
        check(seq_state, 0, 0);
        brownout_low = 0;
        wait_run;
        check(pw, (PW - 1) * 16, PW * 16 + 4);
        check(os, 0, 0);
        wake_from_sleep = 1;
        hold(4);
        wake_from_sleep = 0;
        wait_run;
        check(os, (OS - 1) * 4, OS * 4 + 4);
        check(pw, 0, 0);
        {other_reset, brownout_low} = 2'h3;
        hold(6);
        check(core_reset, 1, 1);
        other_reset = 0;
        hold(20);
        check(core_reset, 1, 1);
        brownout_low = 0;
        wait_run;
        check(pw, (PW - 1) * 16, PW * 16 + 4);
        complete_run;
    end
    initial
    begin
        hold(20000);
        fails = fails + 1;
        complete_run;
    end
endmodule
